// ---- cfg_pkg.sv ----
package cfg_pkg;
	localparam logic [3:0] ADDR_CONFIG = 4'h8;
	localparam logic [3:0] ADDR_MAP_CRC = 4'hF;
	localparam logic [3:0] ADDR_FILTER = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;
	localparam logic [7:0] CONFIG_RESET = 8'h08;
	localparam logic [7:0] CONFIG_WMASK = 8'hF7;
	localparam logic [7:0] CRC_RESET = 8'h00;
	localparam logic [4:0] FILTER_RESET = 5'h00;
	localparam int BIT_CLK_SEL = 7;
	localparam int BIT_CLK_DIV = 6;
	localparam int BIT_DRIVE = 5;
	localparam int BIT_UNIPOLAR = 4;
	localparam int BIT_FIXED_ONE = 3;
	localparam int BIT_FRAME_CRC = 2;
	localparam int BIT_MAP_CRC = 1;
	localparam int BIT_STATUS_EN = 0;
	localparam int EVT_FRAME_ERR = 0;
	localparam int EVT_REG_ERR = 1;
	localparam logic [3:0] EXT_DIV_RATIO = 4'h8;
	typedef enum logic [2:0] {
		FMODE_WIDEBAND = 3'b000,
		FMODE_SINC4 = 3'b001,
		FMODE_SINC4_SINC1 = 3'b010,
		FMODE_SINC3 = 3'b011,
		FMODE_SINC3_SINC1 = 3'b100
	} filter_mode_t;
endpackage

// ---- filter_decode.sv ----
`timescale 1ns/100ps
module filter_decode
	import cfg_pkg::*;
(
	input wire logic [4:0] code,
	output filter_mode_t mode,
	output logic [15:0] osr_first,
	output logic [15:0] osr_second
);
	always_comb begin
		mode = FMODE_WIDEBAND;
		osr_first = 16'h0000;
		osr_second = 16'h0001;
		case (code)
			5'h00: osr_first = 16'h0020;
			5'h01: osr_first = 16'h0040;
			5'h02: osr_first = 16'h0080;
			5'h03: osr_first = 16'h0100;
			5'h04: osr_first = 16'h0200;
			5'h05: osr_first = 16'h0400;
			5'h06: osr_first = 16'h0800;
			5'h07: osr_first = 16'h1000;
			5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
			5'h10, 5'h11, 5'h12: begin
				mode = FMODE_SINC4;
				case (code)
					5'h08: osr_first = 16'h000C;
					5'h09: osr_first = 16'h0010;
					5'h0A: osr_first = 16'h0018;
					5'h0B: osr_first = 16'h0020;
					5'h0C: osr_first = 16'h0040;
					5'h0D: osr_first = 16'h0080;
					5'h0E: osr_first = 16'h0100;
					5'h0F: osr_first = 16'h0200;
					5'h10: osr_first = 16'h0400;
					5'h11: osr_first = 16'h0800;
					default: osr_first = 16'h1000;
				endcase
			end
			5'h1C: begin
				mode = FMODE_SINC3;
				osr_first = 16'h682B;
			end
			5'h1D: begin
				mode = FMODE_SINC3;
				osr_first = 16'h7D00;
			end
			5'h1E: begin
				mode = FMODE_SINC3_SINC1;
				osr_first = 16'h7D00;
				osr_second = 16'h0003;
			end
			5'h1F: begin
				mode = FMODE_SINC3_SINC1;
				osr_first = 16'h7D00;
				osr_second = 16'h0005;
			end
			default: begin
				mode = FMODE_SINC4_SINC1;
				osr_first = 16'h0020;
				case (code)
					5'h13: osr_second = 16'h0002;
					5'h14: osr_second = 16'h0004;
					5'h15: osr_second = 16'h000A;
					5'h16: osr_second = 16'h0014;
					5'h17: osr_second = 16'h0028;
					5'h18: osr_second = 16'h0064;
					5'h19: osr_second = 16'h00C8;
					5'h1A: osr_second = 16'h0190;
					default: osr_second = 16'h03E8;
				endcase
			end
		endcase
	end
endmodule

// ---- cfg_regs.sv ----
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module cfg_regs
	import cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic frame_crc_mismatch,
	input wire logic [7:0] map_crc_computed,
	output logic ext_clk_sel,
	output logic ext_clk_div8,
	output logic output_drive_half,
	output logic unipolar_coding_sel,
	output logic frame_crc_en,
	output logic map_crc_en,
	output logic status_prefix_en,
	output logic [7:0] status_flags,
	output filter_mode_t filter_mode,
	output logic [15:0] filter_osr_first,
	output logic [15:0] filter_osr_second,
	output logic irq
);
	typedef struct packed {
		logic [7:0] config_byte;
		logic [7:0] map_crc;
		logic [4:0] filter_code;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic ack;
		logic [31:0] rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic access;
	logic wr_hit;
	logic [1:0] evt;
	logic [1:0] clr;

	assign access = (avs_read | avs_write) & ~st_reg.ack;
	// writes land on the completion edge, the one where waitrequest is seen low
	assign wr_hit = avs_write & st_reg.ack & avs_byteenable[0];
	// one wait cycle per access so read data always comes from a flop
	assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
	assign avs_readdata = st_reg.rdata;

	always_comb begin
		evt = 2'b00;
		clr = 2'b00;
		evt[EVT_FRAME_ERR] = frame_crc_mismatch & st_reg.config_byte[BIT_FRAME_CRC];
		// comparison only while enabled, else a stray mismatch would flag scratchpad use
		evt[EVT_REG_ERR] = st_reg.config_byte[BIT_MAP_CRC] &
			(map_crc_computed != st_reg.map_crc);
		if (wr_hit && avs_address == ADDR_IRQ_CLEAR) begin
			clr = avs_writedata[1:0];
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.ack = access;
		// set beats clear in the same cycle
		st_next.irq_status = (st_reg.irq_status & ~clr) | evt;
		if (wr_hit) begin
			case (avs_address)
				ADDR_CONFIG: st_next.config_byte = (avs_writedata[7:0] & CONFIG_WMASK) |
					CONFIG_RESET;
				ADDR_MAP_CRC: st_next.map_crc = avs_writedata[7:0];
				ADDR_FILTER: st_next.filter_code = avs_writedata[4:0];
				ADDR_IRQ_ENABLE: st_next.irq_enable = avs_writedata[1:0];
				default: st_next.map_crc = st_reg.map_crc;
			endcase
		end
		if (avs_read && access) begin
			case (avs_address)
				ADDR_CONFIG: st_next.rdata = {24'h000000, st_reg.config_byte};
				ADDR_MAP_CRC: st_next.rdata = {24'h000000, st_reg.map_crc};
				ADDR_FILTER: st_next.rdata = {27'h0000000, st_reg.filter_code};
				ADDR_IRQ_STATUS: st_next.rdata = {30'h00000000, st_reg.irq_status};
				ADDR_IRQ_ENABLE: st_next.rdata = {30'h00000000, st_reg.irq_enable};
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		if (reset) begin
			st_next.config_byte = CONFIG_RESET;
			st_next.map_crc = CRC_RESET;
			st_next.filter_code = FILTER_RESET;
			st_next.irq_status = 2'b00;
			st_next.irq_enable = 2'b00;
			st_next.ack = 1'b0;
			st_next.rdata = 32'h00000000;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_reg <= st_next;
	end

	assign ext_clk_sel = st_reg.config_byte[BIT_CLK_SEL];
	assign ext_clk_div8 = st_reg.config_byte[BIT_CLK_DIV];
	assign output_drive_half = st_reg.config_byte[BIT_DRIVE];
	assign unipolar_coding_sel = st_reg.config_byte[BIT_UNIPOLAR];
	assign frame_crc_en = st_reg.config_byte[BIT_FRAME_CRC];
	assign map_crc_en = st_reg.config_byte[BIT_MAP_CRC];
	assign status_prefix_en = st_reg.config_byte[BIT_STATUS_EN];
	assign status_flags = {6'h00, st_reg.irq_status};
	assign irq = |(st_reg.irq_status & st_reg.irq_enable);

	filter_decode u_dec (
		.code(st_reg.filter_code),
		.mode(filter_mode),
		.osr_first(filter_osr_first),
		.osr_second(filter_osr_second)
	);

	property p_fixed_one;
		@(posedge sys_clk) disable iff (reset) st_reg.config_byte[BIT_FIXED_ONE];
	endproperty
	a_fixed_one: assert property (p_fixed_one) else $error("fixed bit not one");

	property p_frame_set;
		@(posedge sys_clk) disable iff (reset)
			frame_crc_mismatch && frame_crc_en |=> status_flags[EVT_FRAME_ERR];
	endproperty
	a_frame_set: assert property (p_frame_set) else $error("frame error not set");

	property p_frame_hold;
		@(posedge sys_clk) disable iff (reset)
			status_flags[EVT_FRAME_ERR] && !clr[EVT_FRAME_ERR] |=> status_flags[EVT_FRAME_ERR];
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame error lost");

	property p_frame_off;
		@(posedge sys_clk) disable iff (reset)
			!status_flags[EVT_FRAME_ERR] && !frame_crc_en |=> !status_flags[EVT_FRAME_ERR];
	endproperty
	a_frame_off: assert property (p_frame_off) else $error("frame error while off");

	property p_reg_set;
		@(posedge sys_clk) disable iff (reset)
			map_crc_en && map_crc_computed != st_reg.map_crc |=> status_flags[EVT_REG_ERR];
	endproperty
	a_reg_set: assert property (p_reg_set) else $error("register error not set");

	property p_scratch;
		@(posedge sys_clk) disable iff (reset)
			!map_crc_en && !status_flags[EVT_REG_ERR] |=> !status_flags[EVT_REG_ERR];
	endproperty
	a_scratch: assert property (p_scratch) else $error("scratchpad flagged");

	property p_crc_write;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_MAP_CRC |=> st_reg.map_crc == $past(avs_writedata[7:0]);
	endproperty
	a_crc_write: assert property (p_crc_write) else $error("crc byte not stored");

	property p_cfg_write;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG |=>
			ext_clk_sel == $past(avs_writedata[7]) && unipolar_coding_sel == $past(avs_writedata[4]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

	property p_sinc3;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code == 5'h1F |-> filter_mode == FMODE_SINC3_SINC1 &&
			filter_osr_second == 16'h0005;
	endproperty
	a_sinc3: assert property (p_sinc3) else $error("filter decode wrong");

	property p_wait;
		@(posedge sys_clk) disable iff (reset)
			avs_read && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("read stalled");

	property p_div_drive;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG |=>
			ext_clk_div8 == $past(avs_writedata[6]) &&
			output_drive_half == $past(avs_writedata[5]);
	endproperty
	a_div_drive: assert property (p_div_drive) else $error("divider or drive not stored");

	property p_crc_bits;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG |=>
			frame_crc_en == $past(avs_writedata[2]) &&
			map_crc_en == $past(avs_writedata[1]);
	endproperty
	a_crc_bits: assert property (p_crc_bits) else $error("crc enables not stored");

	property p_status_bit;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG |=>
			status_prefix_en == $past(avs_writedata[0]);
	endproperty
	a_status_bit: assert property (p_status_bit) else $error("status prefix not stored");

	property p_bipolar;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG && !avs_writedata[BIT_UNIPOLAR] |=>
			!unipolar_coding_sel;
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("bipolar not selected");

	property p_unipolar;
		@(posedge sys_clk) disable iff (reset)
			wr_hit && avs_address == ADDR_CONFIG && avs_writedata[BIT_UNIPOLAR] |=>
			unipolar_coding_sel;
	endproperty
	a_unipolar: assert property (p_unipolar) else $error("unipolar not selected");

	// no disable here: this one watches the reset itself
	property p_cfg_reset;
		@(posedge sys_clk)
			reset |=> st_reg.config_byte == CONFIG_RESET && !ext_clk_sel;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");

	property p_cfg_keep;
		@(posedge sys_clk) disable iff (reset)
			!(wr_hit && avs_address == ADDR_CONFIG) |=> $stable(st_reg.config_byte);
	endproperty
	a_cfg_keep: assert property (p_cfg_keep) else $error("config changed without write");

	property p_crc_keep;
		@(posedge sys_clk) disable iff (reset)
			!(wr_hit && avs_address == ADDR_MAP_CRC) |=> $stable(st_reg.map_crc);
	endproperty
	a_crc_keep: assert property (p_crc_keep) else $error("crc byte changed");

	property p_frame_clear;
		@(posedge sys_clk) disable iff (reset)
			status_flags[EVT_FRAME_ERR] && clr[EVT_FRAME_ERR] && !evt[EVT_FRAME_ERR] |=>
			!status_flags[EVT_FRAME_ERR];
	endproperty
	a_frame_clear: assert property (p_frame_clear) else $error("frame error not cleared");

	property p_reg_hold;
		@(posedge sys_clk) disable iff (reset)
			status_flags[EVT_REG_ERR] && !clr[EVT_REG_ERR] |=> status_flags[EVT_REG_ERR];
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("register error lost");

	property p_irq_quiet;
		@(posedge sys_clk) disable iff (reset)
			status_flags[1:0] == 2'b00 |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without status");

	property p_flags_spare;
		@(posedge sys_clk) disable iff (reset)
			status_flags[7:2] == 6'h00;
	endproperty
	a_flags_spare: assert property (p_flags_spare) else $error("spare status bits set");

	property p_sinc4_sinc1;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code inside {[5'h16:5'h1B]} |->
			filter_mode == FMODE_SINC4_SINC1 && filter_osr_first == 16'h0020;
	endproperty
	a_sinc4_sinc1: assert property (p_sinc4_sinc1) else $error("cascade decode wrong");

	property p_sinc1_top;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code == 5'h1B |-> filter_osr_second == 16'h03E8;
	endproperty
	a_sinc1_top: assert property (p_sinc1_top) else $error("top cascade ratio wrong");

	property p_sinc3_low;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code == 5'h1C |->
			filter_mode == FMODE_SINC3 && filter_osr_first == 16'h682B;
	endproperty
	a_sinc3_low: assert property (p_sinc3_low) else $error("lone sinc3 low wrong");

	property p_sinc3_high;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code == 5'h1D |->
			filter_mode == FMODE_SINC3 && filter_osr_first == 16'h7D00;
	endproperty
	a_sinc3_high: assert property (p_sinc3_high) else $error("lone sinc3 high wrong");

	property p_sinc3_three;
		@(posedge sys_clk) disable iff (reset)
			st_reg.filter_code == 5'h1E |->
			filter_mode == FMODE_SINC3_SINC1 && filter_osr_second == 16'h0003;
	endproperty
	a_sinc3_three: assert property (p_sinc3_three) else $error("sinc3 by three wrong");

	property p_write_wait;
		@(posedge sys_clk) disable iff (reset)
			avs_write && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_write_wait: assert property (p_write_wait) else $error("write stalled");

	property p_cfg_read;
		@(posedge sys_clk) disable iff (reset)
			avs_read && !avs_waitrequest && avs_address == ADDR_CONFIG |->
			avs_readdata[BIT_FIXED_ONE] && avs_readdata[31:8] == 24'h000000;
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

	c_irq: cover property (@(posedge sys_clk) disable iff (reset) irq);
	c_both: cover property (@(posedge sys_clk) disable iff (reset) status_flags[1:0] == 2'b11);
	c_clear: cover property (@(posedge sys_clk) disable iff (reset) |clr && |evt);
	c_ext_div: cover property (@(posedge sys_clk) disable iff (reset) ext_clk_sel && ext_clk_div8);
	c_cascade: cover property (@(posedge sys_clk) disable iff (reset)
		filter_mode == FMODE_SINC3_SINC1);
endmodule

// ---- host_crc_model.sv ----
`timescale 1ns/100ps
module host_crc_model
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic bad_frame,
	input wire logic [7:0] crc_now,
	output logic frame_crc_mismatch,
	output logic [7:0] map_crc_computed
);
	// registered like the real frame checker, so the mismatch lands one edge after the request and the status flag two
	always_ff @(posedge sys_clk) begin
		frame_crc_mismatch <= reset ? 1'b0 : bad_frame;
		map_crc_computed <= reset ? 8'h00 : crc_now;
	end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	import cfg_pkg::*;
	logic sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0, bad_frame = 0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [7:0] crc_now = 8'h00, status_flags, map_crc_computed, r, cfg, pins;
	logic avs_waitrequest, frame_crc_mismatch, ext_clk_sel, ext_clk_div8, irq;
	logic output_drive_half, unipolar_coding_sel, frame_crc_en, map_crc_en, status_prefix_en;
	filter_mode_t filter_mode, em;
	logic [15:0] filter_osr_first, filter_osr_second;
	int mismatches = 0, total_checks = 0, eo;
	int osr2[10] = '{20, 40, 100, 200, 400, 1000, 1, 1, 3, 5};

	always #4 sys_clk = ~sys_clk;

	cfg_regs dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .frame_crc_mismatch,
		.map_crc_computed, .ext_clk_sel, .ext_clk_div8, .output_drive_half,
		.unipolar_coding_sel, .frame_crc_en, .map_crc_en, .status_prefix_en, .status_flags,
		.filter_mode, .filter_osr_first, .filter_osr_second, .irq);

	host_crc_model host (.sys_clk, .reset, .bad_frame, .crc_now, .frame_crc_mismatch,
		.map_crc_computed);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			mismatches++;
		end
	endtask

	// entered at a rising edge; the trailing edge keeps back-to-back calls apart
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		// no local limit: only the watchdog ends a stalled wait
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdchk(input string s, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00, 4'hF);
		chk(s, e, q);
	endtask

	task automatic frame;
		bad_frame <= 1'b1;
		@(posedge sys_clk);
		bad_frame <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish;
	end

	initial begin
		void'($urandom(82));
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rdchk("config", ADDR_CONFIG, 32'h08);
		rdchk("map crc", ADDR_MAP_CRC, 32'h00);
		rdchk("status", ADDR_IRQ_STATUS, 32'h00);
		chk("clock pins", 32'h0, {ext_clk_sel, ext_clk_div8});
		for (int i = 0; i < 12; i++) begin
			r = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			bus(1'b1, ADDR_CONFIG, r, 4'hF);
			cfg = (r & 8'hF7) | 8'h08;
			rdchk("config", ADDR_CONFIG, {24'h0, cfg});
			pins = {ext_clk_sel, ext_clk_div8, output_drive_half, unipolar_coding_sel, 1'b1,
				frame_crc_en, map_crc_en, status_prefix_en};
			chk("config pins", {24'h0, cfg}, {24'h0, pins});
		end
		// low byte lane off and an unmapped index must both leave state untouched
		bus(1'b1, ADDR_CONFIG, ~cfg, 4'hE);
		rdchk("config", ADDR_CONFIG, {24'h0, cfg});
		bus(1'b1, 4'h5, 8'hA5, 4'hF);
		rdchk("unmapped", 4'h5, 32'h0);
		for (int c = 22; c < 32; c++) begin
			bus(1'b1, ADDR_FILTER, 8'(c), 4'hF);
			rdchk("filter code", ADDR_FILTER, 32'(c));
			em = c < 28 ? FMODE_SINC4_SINC1 : c < 30 ? FMODE_SINC3 : FMODE_SINC3_SINC1;
			eo = c < 28 ? 32 : c == 28 ? 26667 : 32000;
			chk("mode", em, filter_mode);
			chk("osr first", eo, filter_osr_first);
			chk("osr second", osr2[c - 22], filter_osr_second);
		end
		bus(1'b1, ADDR_CONFIG, 8'h00, 4'hF);
		frame();
		rdchk("status", ADDR_IRQ_STATUS, 32'h0);
		bus(1'b1, ADDR_IRQ_ENABLE, 8'h03, 4'hF);
		bus(1'b1, ADDR_CONFIG, 8'h04, 4'hF);
		frame();
		rdchk("status", ADDR_IRQ_STATUS, 32'h1);
		chk("status flags", 32'h1, status_flags);
		chk("irq", 32'h1, irq);
		bus(1'b1, ADDR_IRQ_ENABLE, 8'h02, 4'hF);
		chk("irq", 32'h0, irq);
		bus(1'b1, ADDR_IRQ_CLEAR, 8'h01, 4'hF);
		rdchk("status", ADDR_IRQ_STATUS, 32'h0);
		crc_now <= 8'h5A;
		bus(1'b1, ADDR_MAP_CRC, 8'h3C, 4'hF);
		rdchk("map crc", ADDR_MAP_CRC, 32'h3C);
		rdchk("status", ADDR_IRQ_STATUS, 32'h0);
		bus(1'b1, ADDR_CONFIG, 8'h02, 4'hF);
		rdchk("status", ADDR_IRQ_STATUS, 32'h2);
		chk("status flags", 32'h2, status_flags);
		chk("irq", 32'h1, irq);
		// clearing while the mismatch persists must not stick
		bus(1'b1, ADDR_IRQ_CLEAR, 8'h02, 4'hF);
		rdchk("status", ADDR_IRQ_STATUS, 32'h2);
		bus(1'b1, ADDR_MAP_CRC, 8'h5A, 4'hF);
		bus(1'b1, ADDR_IRQ_CLEAR, 8'h02, 4'hF);
		rdchk("status", ADDR_IRQ_STATUS, 32'h0);
		chk("irq", 32'h0, irq);
		tally_and_finish;
	end
endmodule
